// File: hdl/hfrr_top.sv
`timescale 1ns/100ps
// Overview of operation
// - Reading the receive port pops one byte, bit 7 is its msb.
// - Host writes transmit bytes to the transmit port, bit 7 msb, bit 0 lsb.
// - Transmit empty flag is live: high while the transmit fifo holds nothing.
// - Transmit full flag is live: high while the transmit fifo has no room.
// - Underrun flag sets when transmit fifo runs dry without end-of-message.
// - An underrun sends an abort on the link with no host action.
// - Underrun flag stays latched until the host reads the info register.
// - Info register bits 7..3 are unassigned; host ignores them.
// - Source select 0: take Sa bits enabled by the other control register.
// - Source select 1: Sa bits or channels chosen by the route register.
// - Sa/channel select 0: bits 4..0 enable Sa4..Sa8.
// - Sa/channel select 1: route channel data, picked per the mode bit.
// - Mode 0: five select bits name one channel as a binary number.
// - Mode 1: channel block registers pick the set of channels.
// - Channel number has bit 4 as msb and bit 0 as lsb.
// - Suppress bit set drops that DS0 bit; bit 7 is DS0 bit 8.
// - Closing-byte status high while presented byte ends a message; the rx state bit is live, the CLOSING_BYTE pin follows one cycle late.
// - Both fifos hold 64 bytes; not-full means one transmit slot free; TX_NOT_FULL stays high one cycle after the write that fills the fifo.

// fifo with registered full and empty flags, shared by both directions
module hfrr_fifo #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         push,
  input  wire logic [W-1:0] wdata,
  input  wire logic         pop,
  output logic      [W-1:0] head,
  output logic              empty,
  output logic              full
);
  import hfrr_pkg::*;

  logic [W-1:0]       mem [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wptr_r;
  logic [FIFO_AW-1:0] rptr_r;
  logic [FIFO_AW:0]   count_r;
  logic [FIFO_AW:0]   count_nxt;
  logic               do_push;
  logic               do_pop;

  // callers already gate, but guard again so the count can never wrap
  assign do_push   = push & ~full;
  assign do_pop    = pop & ~empty;
  assign count_nxt = count_r + (FIFO_AW+1)'(do_push) - (FIFO_AW+1)'(do_pop);

  // head shows the oldest entry at once, so a read takes it with no wait
  assign head      = mem[rptr_r];

  // storage, no reset needed for data
  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr_r] <= wdata;
    end
  end

  // read and write pointers, wrapping at the depth
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wptr_r <= '0;
      rptr_r <= '0;
    end else begin
      wptr_r <= wptr_r + FIFO_AW'(do_push);
      rptr_r <= rptr_r + FIFO_AW'(do_pop);
    end
  end

  // fill count, one bit wider than the pointers so a full fifo fits
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // flags taken from the next count, so they carry no extra lag
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      empty <= 1'b1;
      full  <= 1'b0;
    end else begin
      empty <= (count_nxt == '0);
      full  <= (count_nxt == (FIFO_AW+1)'(FIFO_DEPTH));
    end
  end
endmodule

module hfrr_top
  import hfrr_pkg::*;
(
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // host register port
  input  wire logic [7:0]            ADDR,
  input  wire logic [7:0]            WDATA,
  input  wire logic                  WR,
  input  wire logic                  RD,
  output logic      [7:0]            RDATA,
  output logic                       IRQ,
  // receive framer bit stream and outside routing controls
  input  wire hfrr_linebit_type      LINE_BIT,
  input  wire logic [4:0]            SA_ENABLE,
  input  wire logic [31:0]           CHAN_BLOCK,
  // routed bits to the receive hdlc controller
  output logic                       HDLC_RX_BIT,
  output logic                       HDLC_RX_VALID,
  // bytes from the receive hdlc controller
  input  wire logic                  RXB_WR,
  input  wire hfrr_rxbyte_type       RXB_BYTE,
  output logic                       RXB_FULL,
  output logic                       CLOSING_BYTE,
  // bytes to the transmit hdlc controller
  input  wire logic                  TXB_RD,
  input  wire logic                  TX_EOM,
  output logic      [7:0]            TXB_DATA,
  output logic                       TXB_VALID,
  output logic                       TX_ABORT,
  output logic                       TX_NOT_FULL
);

  // control registers
  logic [7:0]          route_r;
  logic [7:0]          suppress_r;
  logic [IRQ_BITS-1:0] irq_mask_r;
  logic [IRQ_BITS-1:0] irq_stat_r;
  logic [IRQ_BITS-1:0] irq_stat_nxt;
  logic                underrun_r;
  logic                underrun_nxt;

  // address selects, shared by the strobes and the read mux
  wire sel_rx_port  = (ADDR == ADDR_RX_PORT);
  wire sel_tx_info  = (ADDR == ADDR_TX_INFO);
  wire sel_tx_port  = (ADDR == ADDR_TX_PORT);
  wire sel_route    = (ADDR == ADDR_ROUTE_CTL);
  wire sel_suppress = (ADDR == ADDR_SUPPRESS);
  wire sel_rx_state = (ADDR == ADDR_RX_STATE);
  wire sel_irq_stat = (ADDR == ADDR_INT_STATUS);
  wire sel_irq_mask = (ADDR == ADDR_INT_MASK);

  // decoded accesses
  wire rd_rx_port  = RD & sel_rx_port;
  wire rd_tx_info  = RD & sel_tx_info;
  wire rd_irq_stat = RD & sel_irq_stat;
  wire wr_tx_port  = WR & sel_tx_port;
  wire wr_route    = WR & sel_route;
  wire wr_suppress = WR & sel_suppress;
  wire wr_irq_mask = WR & sel_irq_mask;

  // fifo heads and flags
  hfrr_rxbyte_type   rx_head;
  logic [7:0]        tx_head;
  logic              rx_empty;
  logic              rx_full;
  logic              tx_empty;
  logic              tx_full;

  // receive side: a byte arriving while full is flagged in interrupt status, not stored
  wire rx_push   = RXB_WR & ~rx_full;
  wire rx_drop   = RXB_WR & rx_full;
  wire rx_end_ev = rx_push & RXB_BYTE.last;
  // an empty read pops nothing and returns the stale head
  wire rx_pop    = rd_rx_port & ~rx_empty;
  // presented byte closes a message; an empty fifo presents nothing
  wire rx_closing = rx_head.last & ~rx_empty;

  // transmit side: a write while full is dropped silently
  wire tx_push   = wr_tx_port & ~tx_full;
  wire tx_pop    = TXB_RD & ~tx_empty;
  // the transmitter wanted a byte, none is there and the message is open
  wire urun_evt  = TXB_RD & tx_empty & ~TX_EOM;

  // receive fifo keeps the message-end marker beside each byte
  hfrr_fifo #(
    .W ($bits(hfrr_rxbyte_type))
  ) u_rx_fifo (
    .clk   (CLK),
    .rst_n (RST_N),
    .push  (rx_push),
    .wdata (RXB_BYTE),
    .pop   (rx_pop),
    .head  (rx_head),
    .empty (rx_empty),
    .full  (rx_full)
  );

  // transmit fifo holds host bytes until the transmitter asks
  hfrr_fifo #(
    .W (BYTE_W)
  ) u_tx_fifo (
    .clk   (CLK),
    .rst_n (RST_N),
    .push  (tx_push),
    .wdata (WDATA),
    .pop   (tx_pop),
    .head  (tx_head),
    .empty (tx_empty),
    .full  (tx_full)
  );

  // route register fields
  wire       route_src  = route_r[ROUTE_SRC_BIT];
  wire       route_sads = route_r[ROUTE_SADS_BIT];
  wire       route_mode = route_r[ROUTE_MODE_BIT];
  wire [4:0] chan_num   = route_r[ROUTE_CHAN_MSB:ROUTE_CHAN_LSB];

  // receive routing: pick which enable mask applies to Sa bits
  wire [4:0] sa_mask   = route_src ? chan_num : SA_ENABLE;
  // Sa4 sits at mask bit 4, Sa8 at mask bit 0
  wire [3:0] sa_off    = SA_TOP_NUM - LINE_BIT.sa_num;
  wire       sa_in_rng = (LINE_BIT.sa_num >= 4'h4) && (LINE_BIT.sa_num <= SA_TOP_NUM);
  wire       sa_pick   = LINE_BIT.is_sa & sa_in_rng & sa_mask[sa_off[2:0]];

  // channel path only exists when the route register asks for it
  wire       use_chan  = route_src & route_sads;
  wire       chan_blk  = CHAN_BLOCK[LINE_BIT.slot];
  wire       chan_one  = (LINE_BIT.slot == chan_num);
  wire       chan_hit  = route_mode ? chan_blk : chan_one;
  // suppression applies to channel bits only, never to Sa bits
  wire       bit_kept  = ~suppress_r[LINE_BIT.bit_idx];
  wire       chan_pick = ~LINE_BIT.is_sa & chan_hit & bit_kept;
  wire       route_hit = use_chan ? chan_pick : sa_pick;

  // routed strobe registered so the controller sees a clean pulse
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      HDLC_RX_VALID <= 1'b0;
    end else begin
      HDLC_RX_VALID <= LINE_BIT.strobe & route_hit;
    end
  end

  // data rides along unqualified; only the valid pulse gives it meaning
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      HDLC_RX_BIT <= 1'b0;
    end else begin
      HDLC_RX_BIT <= LINE_BIT.data;
    end
  end

  // route register write
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      route_r <= ROUTE_CTL_RST;
    end else if (wr_route) begin
      route_r <= WDATA;
    end
  end

  // suppress register write
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      suppress_r <= SUPPRESS_RST;
    end else if (wr_suppress) begin
      suppress_r <= WDATA;
    end
  end

  // interrupt mask write; bits above the mask width are dropped
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_mask_r <= IRQ_RST;
    end else if (wr_irq_mask) begin
      irq_mask_r <= WDATA[IRQ_BITS-1:0];
    end
  end

  // sticky flags: a new event in the reading cycle survives the clear
  assign underrun_nxt = urun_evt | (underrun_r & ~rd_tx_info);
  assign irq_stat_nxt = {rx_drop, rx_end_ev, urun_evt}
                      | (irq_stat_r & ~{IRQ_BITS{rd_irq_stat}});

  // underrun flag shown in the transmit info register
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      underrun_r <= 1'b0;
    end else begin
      underrun_r <= underrun_nxt;
    end
  end

  // interrupt status bits, cleared by reading them
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      irq_stat_r <= IRQ_RST;
    end else begin
      irq_stat_r <= irq_stat_nxt;
    end
  end

  // level interrupt from the next status, so it tracks the bits exactly
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(irq_stat_nxt & irq_mask_r);
    end
  end

  // read data mux; unassigned and unmapped bits read as zero
  wire [7:0] tx_info  = {5'h00, tx_empty, tx_full, underrun_r};
  wire [7:0] rx_state = {5'h00, rx_full, rx_closing, rx_empty};
  wire [7:0] irq_stat = {5'h00, irq_stat_r};
  wire [7:0] irq_mask = {5'h00, irq_mask_r};
  wire [7:0] rd_mux =
      sel_rx_port  ? rx_head.data :
      sel_tx_info  ? tx_info :
      sel_route    ? route_r :
      sel_suppress ? suppress_r :
      sel_rx_state ? rx_state :
      sel_irq_stat ? irq_stat :
      sel_irq_mask ? irq_mask : 8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? rd_mux : 8'h00;
    end
  end

  // transmit pulses; abort fires in the cycle after the dry request
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TXB_VALID <= 1'b0;
      TX_ABORT  <= 1'b0;
    end else begin
      TXB_VALID <= tx_pop;
      TX_ABORT  <= urun_evt;
    end
  end

  // byte handed over holds until the next pop
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TXB_DATA <= 8'h00;
    end else if (tx_pop) begin
      TXB_DATA <= tx_head;
    end
  end

  // not-full copy for the host side; a pop frees a slot at once
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      TX_NOT_FULL <= 1'b1;
    end else begin
      TX_NOT_FULL <= ~(tx_full & ~tx_pop) | tx_pop;
    end
  end

  // receive full copy, one cycle behind the fifo flag
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      RXB_FULL <= 1'b0;
    end else begin
      RXB_FULL <= rx_full;
    end
  end

  // closing-byte status, one cycle behind the fifo head
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CLOSING_BYTE <= 1'b0;
    end else begin
      CLOSING_BYTE <= rx_closing;
    end
  end

endmodule

// File: common/hfrr_pkg.sv
package hfrr_pkg;

  // register offsets (byte addresses on the 8-bit host port)
  localparam logic [7:0] ADDR_RX_PORT     = 8'hB4;
  localparam logic [7:0] ADDR_TX_INFO     = 8'hB6;
  localparam logic [7:0] ADDR_TX_PORT     = 8'hB7;
  localparam logic [7:0] ADDR_ROUTE_CTL   = 8'hB8;
  localparam logic [7:0] ADDR_SUPPRESS    = 8'hB9;
  localparam logic [7:0] ADDR_RX_STATE    = 8'hBC;
  localparam logic [7:0] ADDR_INT_STATUS  = 8'hBD;
  localparam logic [7:0] ADDR_INT_MASK    = 8'hBE;

  // transmit_fifo_info field positions
  localparam int TXI_UNDERRUN_BIT = 0;
  localparam int TXI_FULL_BIT     = 1;
  localparam int TXI_EMPTY_BIT    = 2;

  // receive_channel_route_ctl field positions
  localparam int ROUTE_SRC_BIT    = 7;
  localparam int ROUTE_SADS_BIT   = 6;
  localparam int ROUTE_MODE_BIT   = 5;
  localparam int ROUTE_CHAN_MSB   = 4;
  localparam int ROUTE_CHAN_LSB   = 0;

  // rx fifo state register field positions
  localparam int RXS_EMPTY_BIT    = 0;
  localparam int RXS_CLOSING_BIT  = 1;
  localparam int RXS_FULL_BIT     = 2;

  // interrupt status / mask bit positions
  localparam int IRQ_UNDERRUN_BIT = 0;
  localparam int IRQ_RX_END_BIT   = 1;
  localparam int IRQ_RX_DROP_BIT  = 2;
  localparam int IRQ_BITS         = 3;

  // reset values
  localparam logic [7:0] ROUTE_CTL_RST    = 8'h00;
  localparam logic [7:0] SUPPRESS_RST     = 8'h00;
  localparam logic [IRQ_BITS-1:0] IRQ_RST = 3'h0;

  // fifo geometry
  localparam int FIFO_DEPTH  = 64;
  localparam int FIFO_AW     = 6;
  localparam int BYTE_W      = 8;

  // highest Sa bit number on the line
  localparam logic [3:0] SA_TOP_NUM = 4'h8;

  // one bit from the receive framer, with its position in the frame
  typedef struct packed {
    logic       data;     // the received bit
    logic       strobe;   // one cycle per line bit
    logic       is_sa;    // bit is an Sa bit of timeslot 0
    logic [3:0] sa_num;   // Sa number 4..8 when is_sa
    logic [4:0] slot;     // timeslot 0..31
    logic [2:0] bit_idx;  // 7 = DS0 bit 8 (msb), 0 = DS0 bit 1
  } hfrr_linebit_type;

  // byte plus message-end marker as kept in the receive fifo
  typedef struct packed {
    logic              last;
    logic [BYTE_W-1:0] data;
  } hfrr_rxbyte_type;

endpackage

// File: testbench/hfrr_assertions.sv
`timescale 1ns/100ps
module hfrr_checker
  import hfrr_pkg::*;
(
  // clock, reset and host port
  input wire logic             CLK,
  input wire logic             RST_N,
  input wire logic [7:0]       ADDR,
  input wire logic [7:0]       WDATA,
  input wire logic             WR,
  input wire logic             RD,
  input wire logic [7:0]       RDATA,
  // line routing
  input wire hfrr_linebit_type LINE_BIT,
  input wire logic [31:0]      CHAN_BLOCK,
  input wire logic             HDLC_RX_BIT,
  input wire logic             HDLC_RX_VALID,
  // transmit side
  input wire logic             TXB_RD,
  input wire logic             TX_EOM,
  input wire logic             TXB_VALID,
  input wire logic             TX_ABORT
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic [7:0] rte_r;
  logic [7:0] sup_r;
  // shadow copies, so routing can be judged without the register bus
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      rte_r <= 8'h00;
      sup_r <= 8'h00;
    end else if (WR) begin
      if (ADDR == ADDR_ROUTE_CTL) rte_r <= WDATA;
      if (ADDR == ADDR_SUPPRESS) sup_r <= WDATA;
    end
  end
  // channel hit for the two selection modes
  wire ds_hit  = (rte_r[7:5] == 3'h6) ? (LINE_BIT.slot == rte_r[4:0]) :
                 ((rte_r[7:5] == 3'h7) && CHAN_BLOCK[LINE_BIT.slot]);
  wire sup_hit = sup_r[LINE_BIT.bit_idx];
  wire info_rd = RD && (ADDR == ADDR_TX_INFO);
  logic udr_seen_r;
  // underrun seen since the last info read, judged from the abort pulses
  always_ff @(posedge CLK) begin
    if (!RST_N) udr_seen_r <= 1'b0;
    else udr_seen_r <= (udr_seen_r | TX_ABORT) & ~info_rd;
  end

  a_abort_cause: assert property (TX_ABORT |-> $past(TXB_RD) && !$past(TX_EOM))
    else $error("abort without a dry request");
  a_abort_excl: assert property (!(TX_ABORT && TXB_VALID))
    else $error("abort and byte together");
  a_txv_cause: assert property (TXB_VALID |-> $past(TXB_RD))
    else $error("byte without request");
  a_rx_bit: assert property (HDLC_RX_VALID |->
    $past(LINE_BIT.strobe) && HDLC_RX_BIT == $past(LINE_BIT.data))
    else $error("routed bit wrong");
  a_sa_range: assert property (HDLC_RX_VALID && $past(LINE_BIT.is_sa) |->
    $past(LINE_BIT.sa_num) inside {[4:8]})
    else $error("bad Sa number routed");
  a_chan_pick: assert property (HDLC_RX_VALID && !$past(LINE_BIT.is_sa) |->
    $past(ds_hit) && !$past(sup_hit))
    else $error("channel bit routed wrongly");
  a_udr_shown: assert property (info_rd && (udr_seen_r || TX_ABORT) |=> RDATA[TXI_UNDERRUN_BIT])
    else $error("underrun not shown");
  a_udr_clear: assert property (info_rd ##1 (info_rd && !TX_ABORT) |=>
    !RDATA[TXI_UNDERRUN_BIT])
    else $error("underrun not cleared");
  a_flag_excl: assert property (info_rd |=> !(RDATA[TXI_EMPTY_BIT] && RDATA[TXI_FULL_BIT]))
    else $error("empty and full together");
endmodule

// File: testbench/hfrr_host.sv
`timescale 1ns/100ps
// host processor on the register port; each access waits for its own edge
module hfrr_host (
  input  wire logic       clk,
  output logic      [7:0] addr,
  output logic      [7:0] wdata,
  output logic            wr,
  output logic            rd,
  input  wire logic [7:0] rdata
);
  initial begin
    addr  = 8'h00;
    wdata = 8'h00;
    wr    = 1'b0;
    rd    = 1'b0;
  end
  // one-cycle write strobe with address and data
  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // n back-to-back reads; d is sampled in the cycle after the last one
  task rd_reg(input logic [7:0] a, input int n, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    repeat (n) @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
endmodule

// File: testbench/testbench.sv
`timescale 1ns/100ps
module testbench;
  import hfrr_pkg::*;
  typedef struct packed {
    logic [7:0] rte, sup;
    logic sa;
    logic [3:0] san;
    logic [4:0] slot;
    logic [2:0] idx;
    logic exp;
  } hfrr_row_type;
  // route, suppress, Sa?, Sa num, slot, DS0 bit, routed?
  localparam hfrr_row_type ROWS[12] = '{
    '{8'h00, 8'h00, 1'b1, 4'h4, 5'h00, 3'h0, 1'b1}, '{8'h00, 8'h00, 1'b1, 4'h5, 5'h00, 3'h0, 1'b0},
    '{8'h81, 8'h00, 1'b1, 4'h8, 5'h00, 3'h0, 1'b1}, '{8'h81, 8'h00, 1'b1, 4'h4, 5'h00, 3'h0, 1'b0},
    '{8'hC5, 8'h00, 1'b0, 4'h0, 5'h05, 3'h3, 1'b1}, '{8'hC5, 8'h00, 1'b0, 4'h0, 5'h04, 3'h3, 1'b0},
    '{8'hE0, 8'h00, 1'b0, 4'h0, 5'h03, 3'h3, 1'b1}, '{8'hE0, 8'h00, 1'b0, 4'h0, 5'h04, 3'h3, 1'b0},
    '{8'hD0, 8'h00, 1'b0, 4'h0, 5'h10, 3'h1, 1'b1}, '{8'hC5, 8'h80, 1'b0, 4'h0, 5'h05, 3'h7, 1'b0},
    '{8'hC5, 8'h80, 1'b0, 4'h0, 5'h05, 3'h0, 1'b1}, '{8'hC5, 8'h01, 1'b0, 4'h0, 5'h05, 3'h0, 1'b0}};
  logic CLK = 1'b0, RST_N = 1'b0, WR, RD, IRQ, RXB_WR = 1'b0, TXB_RD = 1'b0, TX_EOM = 1'b0;
  logic [7:0] ADDR, WDATA, RDATA, TXB_DATA, d;
  logic [4:0] SA_ENABLE = 5'h10;
  logic [31:0] CHAN_BLOCK = 32'h0000_0008;
  hfrr_linebit_type LINE_BIT = '0;
  hfrr_rxbyte_type RXB_BYTE = '0;
  logic HDLC_RX_BIT, HDLC_RX_VALID, RXB_FULL, CLOSING_BYTE, TXB_VALID, TX_ABORT, TX_NOT_FULL;
  int miscompares = 0, total_checks = 0;
  always #10 CLK = ~CLK;
  hfrr_top i_hfrr_top (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
    .RDATA(RDATA), .IRQ(IRQ), .LINE_BIT(LINE_BIT), .SA_ENABLE(SA_ENABLE), .CHAN_BLOCK(CHAN_BLOCK),
    .HDLC_RX_BIT(HDLC_RX_BIT), .HDLC_RX_VALID(HDLC_RX_VALID), .RXB_WR(RXB_WR), .RXB_BYTE(RXB_BYTE),
    .RXB_FULL(RXB_FULL), .CLOSING_BYTE(CLOSING_BYTE), .TXB_RD(TXB_RD), .TX_EOM(TX_EOM),
    .TXB_DATA(TXB_DATA), .TXB_VALID(TXB_VALID), .TX_ABORT(TX_ABORT), .TX_NOT_FULL(TX_NOT_FULL));
  hfrr_host i_hfrr_host (.clk(CLK), .addr(ADDR), .wdata(WDATA), .wr(WR), .rd(RD), .rdata(RDATA));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task stop_test;
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // one request from the transmit controller, result looked at after the edge
  task txrd;
    @(posedge CLK);
    TXB_RD <= 1'b1;
    @(posedge CLK);
    TXB_RD <= 1'b0;
    #1;
  endtask
  initial begin
    repeat (5000) @(posedge CLK);
    miscompares++;
    stop_test;
  end
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    #1 chk("not_full", 8'h01, {7'h0, TX_NOT_FULL});
    i_hfrr_host.rd_reg(ADDR_TX_INFO, 1, d);
    chk("info", 8'h04, {5'h0, d[2:0]});
    foreach (ROWS[i]) begin
      i_hfrr_host.wr_reg(ADDR_ROUTE_CTL, ROWS[i].rte);
      i_hfrr_host.wr_reg(ADDR_SUPPRESS, ROWS[i].sup);
      @(posedge CLK);
      LINE_BIT <= {1'b1, 1'b1, ROWS[i].sa, ROWS[i].san, ROWS[i].slot, ROWS[i].idx};
      @(posedge CLK);
      LINE_BIT.strobe <= 1'b0;
      #1 chk("rx_valid", {7'h0, ROWS[i].exp}, {7'h0, HDLC_RX_VALID});
      if (ROWS[i].exp) chk("rx_bit", 8'h01, {7'h0, HDLC_RX_BIT});
    end
    // underrun while masked, then unmask, then clear by status read
    txrd;
    chk("abort", 8'h01, {7'h0, TX_ABORT});
    repeat (2) @(posedge CLK);
    #1 chk("irq", 8'h00, {7'h0, IRQ});
    i_hfrr_host.wr_reg(ADDR_INT_MASK, 8'h01);
    repeat (2) @(posedge CLK);
    #1 chk("irq", 8'h01, {7'h0, IRQ});
    i_hfrr_host.rd_reg(ADDR_TX_INFO, 1, d);
    chk("info", 8'h05, {5'h0, d[2:0]});
    i_hfrr_host.rd_reg(ADDR_TX_INFO, 2, d);
    chk("info", 8'h04, {5'h0, d[2:0]});
    i_hfrr_host.rd_reg(ADDR_INT_STATUS, 1, d);
    chk("status", 8'h01, d);
    repeat (2) @(posedge CLK);
    #1 chk("irq", 8'h00, {7'h0, IRQ});
    // fill to refusal, then drain; the extra byte must vanish
    for (int i = 0; i < FIFO_DEPTH; i++) i_hfrr_host.wr_reg(ADDR_TX_PORT, i[7:0]);
    i_hfrr_host.rd_reg(ADDR_TX_INFO, 1, d);
    chk("info", 8'h02, {5'h0, d[2:0]});
    chk("not_full", 8'h00, {7'h0, TX_NOT_FULL});
    i_hfrr_host.wr_reg(ADDR_TX_PORT, 8'hEE);
    for (int i = 0; i < FIFO_DEPTH; i++) begin
      txrd;
      chk("tx_data", i[7:0], TXB_VALID ? TXB_DATA : 8'hFF);
    end
    i_hfrr_host.rd_reg(ADDR_TX_INFO, 1, d);
    chk("info", 8'h04, {5'h0, d[2:0]});
    @(posedge CLK) TX_EOM <= 1'b1;
    txrd;
    chk("eom_quiet", 8'h00, {6'h0, TX_ABORT, TXB_VALID});
    // receive bytes: first plain, second closes the message
    @(posedge CLK);
    RXB_WR <= 1'b1;
    RXB_BYTE <= {1'b0, 8'hA5};
    @(posedge CLK);
    RXB_BYTE <= {1'b1, 8'h3C};
    @(posedge CLK);
    RXB_WR <= 1'b0;
    repeat (2) @(posedge CLK);
    #1 chk("closing", 8'h00, {7'h0, CLOSING_BYTE});
    i_hfrr_host.rd_reg(ADDR_RX_PORT, 1, d);
    chk("rx_port", 8'hA5, d);
    repeat (2) @(posedge CLK);
    #1 chk("closing", 8'h01, {7'h0, CLOSING_BYTE});
    chk("rx_full", 8'h00, {7'h0, RXB_FULL});
    i_hfrr_host.rd_reg(ADDR_RX_STATE, 1, d);
    chk("rx_state", 8'h02, d);
    i_hfrr_host.rd_reg(ADDR_RX_PORT, 1, d);
    chk("rx_port", 8'h3C, d);
    i_hfrr_host.rd_reg(ADDR_RX_STATE, 1, d);
    chk("rx_state", 8'h01, d);
    i_hfrr_host.rd_reg(ADDR_INT_STATUS, 1, d);
    chk("status", 8'h02, d);
    i_hfrr_host.rd_reg(8'h10, 1, d);
    chk("unmapped", 8'h00, d);
    stop_test;
  end
endmodule
bind hfrr_top hfrr_checker i_hfrr_checker (.CLK(CLK), .RST_N(RST_N), .ADDR(ADDR), .WDATA(WDATA),
  .WR(WR), .RD(RD), .RDATA(RDATA), .LINE_BIT(LINE_BIT), .CHAN_BLOCK(CHAN_BLOCK),
  .HDLC_RX_BIT(HDLC_RX_BIT), .HDLC_RX_VALID(HDLC_RX_VALID), .TXB_RD(TXB_RD), .TX_EOM(TX_EOM),
  .TXB_VALID(TXB_VALID), .TX_ABORT(TX_ABORT));
